//--- sps_pkg.sv
package sps_pkg;
    localparam int SPS_DEPTH = 3;
    localparam int PAGE_W = 8;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_LIVE = 8'h84;
    localparam logic [7:0] IDX_SECOND = 8'h85;
    localparam logic [7:0] IDX_THIRD = 8'h86;
    localparam logic [7:0] IDX_CTRL = 8'h96;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 9;
    localparam int CTRL_EN_BIT = 0;
    localparam logic [PAGE_W-1:0] PAGE_RST = 8'h00;
    localparam logic CTRL_EN_RST = 1'b1;
    localparam logic [1:0] HRESP_OKAY = 2'h0;
    localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0;

    typedef enum logic [2:0] {SPS_SEL_NONE, SPS_SEL_LIVE, SPS_SEL_SECOND, SPS_SEL_THIRD, SPS_SEL_CTRL} sps_sel_t;
    typedef enum {SPS_BUS_IDLE, SPS_BUS_WR, SPS_BUS_RD} sps_bus_t;
endpackage : sps_pkg

//--- sps_stack_if.sv
interface sps_stack_if;
    import sps_pkg::*;
    logic push;
    logic pop;
    logic [PAGE_W-1:0] push_page;
    logic [PAGE_W-1:0] wr_data;
    logic [SPS_DEPTH-1:0] wr_sel;
    logic [PAGE_W-1:0] entry [SPS_DEPTH];

    modport ctl (output push, output pop, output push_page, output wr_data, output wr_sel, input entry);
    modport stk (input push, input pop, input push_page, input wr_data, input wr_sel, output entry);
endinterface : sps_stack_if

//--- sps_page_stack.sv
module sps_page_stack (
    input wire logic clk_sys, // System clock
    input wire logic srst, // Synchronous reset, active high
    sps_stack_if.stk st // Shift and write requests, entries out
);
    import sps_pkg::*;

    logic [PAGE_W-1:0] stk_r [SPS_DEPTH];
    logic [PAGE_W-1:0] stk_nxt [SPS_DEPTH];

    if (SPS_DEPTH < 2) begin : g_chk
        $error("page stack needs at least two entries");
    end

    ////////////////////////////////////////////////////////////////////////
    for (genvar i = 0; i < SPS_DEPTH; i++) begin : g_ent
        logic [PAGE_W-1:0] from_below;
        logic [PAGE_W-1:0] from_above;
        if (i == 0) begin : g_top
            assign from_below = st.push_page;
        end else begin : g_mid
            assign from_below = stk_r[i-1];
        end
        // Last entry keeps its value on a pop, so it can be popped again
        if (i == SPS_DEPTH - 1) begin : g_last
            assign from_above = stk_r[i];
        end else begin : g_inner
            assign from_above = stk_r[i+1];
        end

        always_comb begin
            stk_nxt[i] = stk_r[i];
            if (st.push) begin
                stk_nxt[i] = from_below;
            end else if (st.pop) begin
                stk_nxt[i] = from_above;
            end
            // Software write lands after any shift of the same cycle
            if (st.wr_sel[i]) begin
                stk_nxt[i] = st.wr_data;
            end
        end

        always_ff @(posedge clk_sys) begin
            if (srst) begin
                stk_r[i] <= PAGE_RST;
            end else begin
                stk_r[i] <= stk_nxt[i];
            end
        end

        assign st.entry[i] = stk_r[i];
    end

    ////////////////////////////////////////////////////////////////////////
    sequence s_quiet;
        !st.push && !st.pop && (st.wr_sel == '0);
    endsequence

    sequence s_third_write;
        st.wr_sel[2] && !st.push && !st.pop;
    endsequence

    sequence s_clean_pop;
        st.pop && !st.push && (st.wr_sel == '0);
    endsequence

    property p_push;
        @(posedge clk_sys) disable iff (srst)
        (st.push && st.wr_sel == '0) |=> (stk_r[0] == $past(st.push_page)) && (stk_r[1] == $past(stk_r[0]))
            && (stk_r[2] == $past(stk_r[1]));
    endproperty
    a_push: assert property (p_push) else $error("push did not shift the stack down");

    property p_pop;
        @(posedge clk_sys) disable iff (srst)
        s_clean_pop |=> (stk_r[0] == $past(stk_r[1])) && (stk_r[1] == $past(stk_r[2])) && $stable(stk_r[2]);
    endproperty
    a_pop: assert property (p_pop) else $error("pop did not shift the stack up");

    property p_hold;
        @(posedge clk_sys) disable iff (srst)
        s_quiet |=> $stable(stk_r[0]) && $stable(stk_r[1]) && $stable(stk_r[2]);
    endproperty
    a_hold: assert property (p_hold) else $error("stack moved without push, pop or write");

    property p_write_only;
        @(posedge clk_sys) disable iff (srst)
        (st.wr_sel == 3'h2 && !st.push && !st.pop) |=> (stk_r[1] == $past(st.wr_data))
            && $stable(stk_r[0]) && $stable(stk_r[2]);
    endproperty
    a_write_only: assert property (p_write_only) else $error("write touched another entry");

    property p_third_to_second;
        @(posedge clk_sys) disable iff (srst)
        s_third_write ##1 s_clean_pop |=> stk_r[1] == $past(st.wr_data, 2);
    endproperty
    a_third_to_second: assert property (p_third_to_second) else $error("third entry not popped to second");
endmodule : sps_page_stack

//--- sps_page_ctx.sv
// Behaviour
// - Page context lives in a three-byte stack: live page, second, third.
// - Interrupt entry pushes the stack; interrupt return pops it, restoring the page.
// - Only interrupt entry and interrupt return shift the stack.
// - Software reads and writes any entry directly, without push or pop.
// - Writing the third byte sets the value popped into second next return.
// - Return copies second into live page and third into second.
// - Clearing auto page switch enable stops page switching, push and pop.
module sps_page_ctx #(
    parameter int ADDR_W = sps_pkg::ADDR_W // Bus address width
) (
    input wire logic clk_sys, // System clock, 100 MHz
    input wire logic srst, // Synchronous reset, active high
    input wire logic hsel, // Slave select
    input wire logic [ADDR_W-1:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Transfer size, word only
    input wire logic [sps_pkg::DATA_W-1:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    output logic hreadyout, // Slave ready
    output logic [sps_pkg::DATA_W-1:0] hrdata, // Read data
    output logic [1:0] hresp, // Always OKAY
    input wire logic irq_enter, // Pulse: interrupt being serviced
    input wire logic [sps_pkg::PAGE_W-1:0] irq_page, // Page of the serviced interrupt
    input wire logic irq_return, // Pulse: return from interrupt
    output logic [sps_pkg::PAGE_W-1:0] live_page_select, // Current page
    output logic auto_page_switch_enable // Automatic switching enabled
);
    import sps_pkg::*;

    if (ADDR_W < IDX_MSB + 1) begin : g_chk
        $error("address too narrow for the register map");
    end

    sps_stack_if st ();

    sps_bus_t state_r;
    sps_bus_t state_nxt;
    sps_sel_t sel_r;
    sps_sel_t sel_nxt;
    logic hreadyout_r;
    logic hreadyout_nxt;
    logic [DATA_W-1:0] hrdata_r;
    logic [DATA_W-1:0] hrdata_nxt;
    logic en_r;
    logic en_nxt;
    logic accept;

    // Unaligned or out-of-map addresses select nothing: writes drop, reads give zero
    function automatic sps_sel_t decode(input logic [ADDR_W-1:0] a);
        sps_sel_t s;
        s = SPS_SEL_NONE;
        if (a[IDX_LSB-1:0] == '0 && (a >> (IDX_MSB + 1)) == '0) begin
            case (a[IDX_MSB:IDX_LSB])
                IDX_LIVE: s = SPS_SEL_LIVE;
                IDX_SECOND: s = SPS_SEL_SECOND;
                IDX_THIRD: s = SPS_SEL_THIRD;
                IDX_CTRL: s = SPS_SEL_CTRL;
                default: s = SPS_SEL_NONE;
            endcase
        end
        return s;
    endfunction : decode

    ////////////////////////////////////////////////////////////////////////
    assign accept = hsel && hready && htrans[1];

    always_comb begin
        state_nxt = SPS_BUS_IDLE;
        sel_nxt = sel_r;
        hreadyout_nxt = 1'b1;
        hrdata_nxt = hrdata_r;
        en_nxt = en_r;
        if (state_r == SPS_BUS_RD) begin
            // One wait state so a read sees any write of the cycle before
            hrdata_nxt = RDATA_ZERO;
            case (sel_r)
                SPS_SEL_LIVE: hrdata_nxt[PAGE_W-1:0] = st.entry[0];
                SPS_SEL_SECOND: hrdata_nxt[PAGE_W-1:0] = st.entry[1];
                SPS_SEL_THIRD: hrdata_nxt[PAGE_W-1:0] = st.entry[2];
                SPS_SEL_CTRL: hrdata_nxt[CTRL_EN_BIT] = en_r;
                default: hrdata_nxt = RDATA_ZERO;
            endcase
        end else begin
            if (state_r == SPS_BUS_WR && sel_r == SPS_SEL_CTRL) begin
                en_nxt = hwdata[CTRL_EN_BIT];
            end
            if (accept) begin
                sel_nxt = decode(haddr);
                state_nxt = hwrite ? SPS_BUS_WR : SPS_BUS_RD;
                hreadyout_nxt = hwrite;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_r <= SPS_BUS_IDLE;
            sel_r <= SPS_SEL_NONE;
            hreadyout_r <= 1'b1;
            hrdata_r <= RDATA_ZERO;
            en_r <= CTRL_EN_RST;
        end else begin
            state_r <= state_nxt;
            sel_r <= sel_nxt;
            hreadyout_r <= hreadyout_nxt;
            hrdata_r <= hrdata_nxt;
            en_r <= en_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Push takes precedence if entry and return ever coincide
    assign st.push = irq_enter && en_r;
    assign st.pop = irq_return && !irq_enter && en_r;
    assign st.push_page = irq_page;
    assign st.wr_data = hwdata[PAGE_W-1:0];

    always_comb begin
        st.wr_sel = '0;
        if (state_r == SPS_BUS_WR) begin
            case (sel_r)
                SPS_SEL_LIVE: st.wr_sel = 3'h1;
                SPS_SEL_SECOND: st.wr_sel = 3'h2;
                SPS_SEL_THIRD: st.wr_sel = 3'h4;
                default: st.wr_sel = '0;
            endcase
        end
    end

    sps_page_stack u_stack (
        .clk_sys(clk_sys),
        .srst(srst),
        .st(st)
    );

    assign hreadyout = hreadyout_r;
    assign hrdata = hrdata_r;
    assign hresp = HRESP_OKAY;
    assign live_page_select = st.entry[0];
    assign auto_page_switch_enable = en_r;

    ////////////////////////////////////////////////////////////////////////
    sequence s_read_taken;
        accept && !hwrite;
    endsequence

    property p_read_timing;
        @(posedge clk_sys) disable iff (srst)
        s_read_taken |=> !hreadyout ##1 hreadyout;
    endproperty
    a_read_timing: assert property (p_read_timing) else $error("read answer not after one wait state");

    property p_disabled;
        @(posedge clk_sys) disable iff (srst)
        (!en_r && state_r != SPS_BUS_WR) |=> $stable(live_page_select);
    endproperty
    a_disabled: assert property (p_disabled) else $error("page moved while auto switching off");

    property p_third_reset;
        @(posedge clk_sys) disable iff (srst)
        $fell(srst) |-> st.entry[2] == PAGE_RST;
    endproperty
    a_third_reset: assert property (p_third_reset) else $error("third byte not zero after reset");
endmodule : sps_page_ctx

//--- sps_core_model.sv
module sps_core_model (
    input wire logic clk_sys, // System clock
    output logic irq_enter, // Interrupt service pulse
    output logic [sps_pkg::PAGE_W-1:0] irq_page, // Page of the serviced interrupt
    output logic irq_return // Return pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    import sps_pkg::*;

    initial begin
        irq_enter = 1'b0;
        irq_return = 1'b0;
        irq_page = 8'ha5;
    end

    ////////////////////////////////////////////////////////////////////////
    // Page lines are not held past the pulse, so a stale page cannot pass
    // Gap plus one sets idle cycles after each pulse: a quick core or a slow one
    task automatic enter(input logic [PAGE_W-1:0] p, input int gap);
        irq_enter <= 1'b1;
        irq_page <= p;
        @(posedge clk_sys);
        irq_enter <= 1'b0;
        irq_page <= ~p;
        repeat (gap + 1) @(posedge clk_sys);
    endtask : enter

    task automatic leave(input int gap);
        irq_return <= 1'b1;
        @(posedge clk_sys);
        irq_return <= 1'b0;
        repeat (gap + 1) @(posedge clk_sys);
    endtask : leave
endmodule : sps_core_model

//--- test_sps_page_ctx.sv
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin mismatches++; \
    $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end

module test_sps_page_ctx;
    timeunit 1ns;
    timeprecision 1ps;
    import sps_pkg::*;

    localparam logic [11:0] A_LIVE = {2'b00, IDX_LIVE, 2'b00};
    localparam logic [11:0] A_SEC = {2'b00, IDX_SECOND, 2'b00};
    localparam logic [11:0] A_THIRD = {2'b00, IDX_THIRD, 2'b00};
    localparam logic [11:0] A_CTRL = {2'b00, IDX_CTRL, 2'b00};

    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic hsel = 1'b0;
    logic [ADDR_W-1:0] haddr = '0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [DATA_W-1:0] hwdata = '0;
    logic hready;
    logic hreadyout;
    logic [DATA_W-1:0] hrdata;
    logic [1:0] hresp;
    logic irq_enter;
    logic [PAGE_W-1:0] irq_page;
    logic irq_return;
    logic [PAGE_W-1:0] live_page_select;
    logic auto_page_switch_enable;
    int mismatches = 0;
    int compares = 0;

    assign hready = hreadyout;

    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    sps_page_ctx #(.ADDR_W(ADDR_W)) dut_u (.clk_sys(clk_sys), .srst(srst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq_enter(irq_enter),
        .irq_page(irq_page), .irq_return(irq_return), .live_page_select(live_page_select),
        .auto_page_switch_enable(auto_page_switch_enable));

    sps_core_model core_u (.clk_sys(clk_sys), .irq_enter(irq_enter), .irq_page(irq_page),
        .irq_return(irq_return));

    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim

    ////////////////////////////////////////////////////////////////////////
    // One word transfer; the wait is bounded so a stuck slave ends the run
    task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do begin @(posedge clk_sys); n++; end while (hready !== 1'b1 && n < 40);
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do begin @(posedge clk_sys); n++; end while (hready !== 1'b1 && n < 40);
        rd = hrdata;
        `CHK("hresp", HRESP_OKAY, hresp)
        if (n >= 40) begin
            mismatches++;
            end_sim();
        end
    endtask : bus

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] rd;
        bus(1'b1, a, d, rd);
    endtask : wr

    task automatic rd_chk(input logic [11:0] a, input logic [7:0] ex, input string nm);
        logic [31:0] rd;
        bus(1'b0, a, 8'h00, rd);
        `CHK(nm, {24'h0, ex}, rd)
    endtask : rd_chk

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd_chk(A_LIVE, 8'h00, "live");
        rd_chk(A_SEC, 8'h00, "second");
        rd_chk(A_THIRD, 8'h00, "third");
        rd_chk(A_CTRL, 8'h01, "ctrl");
        `CHK("en", 1'b1, auto_page_switch_enable)
    endtask : t_reset

    task automatic t_push_pop();
        core_u.enter(8'h0f, 0);
        core_u.enter(8'h02, 3);
        `CHK("live", 8'h02, live_page_select)
        rd_chk(A_SEC, 8'h0f, "second");
        rd_chk(A_THIRD, 8'h00, "third");
        core_u.leave(0);
        `CHK("live", 8'h0f, live_page_select)
        core_u.leave(2);
        `CHK("live", 8'h00, live_page_select)
    endtask : t_push_pop

    task automatic t_sw_write();
        wr(A_THIRD, 8'h3c);
        wr(A_SEC, 8'h5a);
        wr(A_LIVE, 8'h11);
        rd_chk(A_THIRD, 8'h3c, "third");
        rd_chk(A_SEC, 8'h5a, "second");
        `CHK("live", 8'h11, live_page_select)
        core_u.leave(0);
        `CHK("live", 8'h5a, live_page_select)
        rd_chk(A_SEC, 8'h3c, "second");
        rd_chk(A_THIRD, 8'h3c, "third");
    endtask : t_sw_write

    task automatic t_disable();
        wr(A_CTRL, 8'h00);
        // The control bit lands at the edge that ends the data phase
        @(posedge clk_sys);
        `CHK("en", 1'b0, auto_page_switch_enable)
        core_u.enter(8'h22, 0);
        `CHK("live", 8'h5a, live_page_select)
        core_u.leave(0);
        `CHK("live", 8'h5a, live_page_select)
        rd_chk(A_SEC, 8'h3c, "second");
        wr(A_CTRL, 8'h01);
        rd_chk(A_CTRL, 8'h01, "ctrl");
    endtask : t_disable

    // Writes elsewhere must not shift or touch the stack
    task automatic t_unmapped();
        wr(12'h000, 8'h77);
        rd_chk(12'h000, 8'h00, "unmapped");
        rd_chk(A_SEC, 8'h3c, "second");
        `CHK("live", 8'h5a, live_page_select)
    endtask : t_unmapped

    // Third byte written in the cycle before a return must be what the pop moves up
    task automatic t_third_pop();
        wr(A_THIRD, 8'h44);
        core_u.leave(0);
        `CHK("live", 8'h3c, live_page_select)
        rd_chk(A_SEC, 8'h44, "second");
    endtask : t_third_pop

    initial begin
        repeat (12) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        t_reset();
        t_push_pop();
        t_sw_write();
        t_disable();
        t_unmapped();
        t_third_pop();
        end_sim();
    end
endmodule : test_sps_page_ctx
